// [rtl/twi_defs.svh]
// Purpose: constants for the two-wire event sequencer
// Assumes: 8-bit registers, Avalon word addressing
// Notes: register offsets are word indices
`ifndef TWI_DEFS_SVH
`define TWI_DEFS_SVH
`define ADDR_CTRL 2'h0
`define ADDR_STAT1 2'h1
`define ADDR_STAT2 2'h2
`define ADDR_DATA 2'h3
`define CTRL_RESET 8'h00
`define CTRL_EN 5
`define CTRL_GC 4
`define CTRL_START 3
`define CTRL_ACK 2
`define CTRL_STOP 1
`define CTRL_IE 0
`define S1_EVENT 7
`define S1_HEADER 6
`define S1_TRA 5
`define S1_BUSY 4
`define S1_BYTE 3
`define S1_ADDR 2
`define S1_MASTER 1
`define S1_START 0
`define S2_AF 4
`define S2_STOP 3
`define S2_ARBITRATION_LOST_FLAG 2
`define S2_BUS_ERROR_FLAG 1
`define S2_GCAL 0
`define SCL_DIV 16'h0004
`endif

// [rtl/twi_pkg.sv]
// Purpose: shared types for the two-wire event sequencer
// Assumes: nothing
// Notes: states of the bit engine
package twi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_BITS = 3'b010,
    ST_HOLD = 3'b011,
    ST_STOP = 3'b100
  } eng_state_t;
endpackage : twi_pkg

// [rtl/twi_if.sv]
// Purpose: shared two-wire bus between device end and far end
// Assumes: open-drain lines, low wins
// Notes: resolves wire levels from the enables
`timescale 1ns/1ps
`default_nettype none
interface twi_if;
  logic sclDevOe; // device pulls clock low
  logic sdaDevOe; // device pulls data low
  logic sclFarOe; // far end pulls clock low
  logic sdaFarOe; // far end pulls data low
  logic scl; // resolved clock level
  logic sda; // resolved data level
  assign scl = ~(sclDevOe | sclFarOe);
  assign sda = ~(sdaDevOe | sdaFarOe);
  modport dev (input scl, sda, output sclDevOe, sdaDevOe);
  modport far (input scl, sda, output sclFarOe, sdaFarOe);
endinterface : twi_if
`default_nettype wire

// [rtl/pin_sync.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input from another domain
// Notes: the output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pin
  input wire logic pinIn,
  output logic pinOut
);
  logic s1_q, s2_q, s3_q; // sync chain

  // chain; first stage feeds only the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // filtered level follows only on agreement
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinOut <= INIT;
    end else if (s2_q == s3_q) begin
      pinOut <= s3_q;
    end
  end
endmodule : pin_sync
`default_nettype wire

// [rtl/twi_far_end.sv]
// Purpose: other party on the bus, a simple target that answers
// Assumes: seven-bit address, byte writes and reads
// Notes: acks its own address, nacks misplaced conditions
`timescale 1ns/1ps
`default_nettype none
module twi_far_end
  import twi_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = 7'h2A
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // bus
  twi_if.far bus,
  // user side
  input wire logic [7:0] txByte,
  output logic [7:0] rxByte,
  output logic rxStrobe,
  output logic misplaced
);
  logic sclS, sdaS, sclP_q, sdaP_q; // filtered lines and history
  logic [3:0] bitCnt_q; // bit within frame, 8 = ack slot
  logic [7:0] sh_q; // shift register
  logic active_q, addrPh_q, rd_q, ackDrv_q, txDrv_q;
  pin_sync u_scl (.sys_clk(sys_clk), .rst(rst), .pinIn(bus.scl),
    .pinOut(sclS));
  pin_sync u_sda (.sys_clk(sys_clk), .rst(rst), .pinIn(bus.sda),
    .pinOut(sdaS));
  wire sclRise = sclS & ~sclP_q;
  wire sclFall = ~sclS & sclP_q;
  wire startC = sclS & sclP_q & sdaP_q & ~sdaS;
  wire stopC = sclS & sclP_q & ~sdaP_q & sdaS;

  // history of the filtered lines
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclP_q <= sclS;
      sdaP_q <= sdaS;
    end
  end

  // frame tracking; a condition mid-byte is answered by nack
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      active_q <= 1'b0;
      addrPh_q <= 1'b0;
      rd_q <= 1'b0;
      bitCnt_q <= 4'h0;
      sh_q <= 8'h00;
      ackDrv_q <= 1'b0;
      txDrv_q <= 1'b0;
      rxByte <= 8'h00;
      rxStrobe <= 1'b0;
      misplaced <= 1'b0;
    end else begin
      rxStrobe <= 1'b0;
      if (startC | stopC) begin
        misplaced <= active_q && bitCnt_q != 4'h0;
        active_q <= startC;
        addrPh_q <= startC;
        // the fall that ends a start is not a bit: count from -1
        bitCnt_q <= startC ? 4'hF : 4'h0;
        ackDrv_q <= 1'b0;
        txDrv_q <= 1'b0;
      end else if (active_q && sclRise && bitCnt_q < 4'h8) begin
        sh_q <= {sh_q[6:0], sdaS};
      end else if (active_q && sclFall) begin
        if (bitCnt_q == 4'h7) begin
          // ack only own address and only when no misplaced condition
          if (addrPh_q) begin
            ackDrv_q <= (sh_q[7:1] == OWN_ADDR) & ~misplaced;
            rd_q <= sh_q[0];
          end else begin
            ackDrv_q <= ~rd_q & ~misplaced;
            rxByte <= sh_q;
            rxStrobe <= ~rd_q;
          end
          txDrv_q <= 1'b0;
          bitCnt_q <= 4'h8;
        end else if (bitCnt_q == 4'h8) begin
          ackDrv_q <= 1'b0;
          if (addrPh_q && !ackDrv_q) begin
            active_q <= 1'b0;
          end
          addrPh_q <= 1'b0;
          sh_q <= txByte;
          txDrv_q <= rd_q & ~txByte[7];
          bitCnt_q <= 4'h0;
        end else begin
          txDrv_q <= rd_q & ~addrPh_q & ~sh_q[6];
          if (rd_q & ~addrPh_q) begin
            sh_q <= {sh_q[6:0], 1'b1};
          end
          bitCnt_q <= bitCnt_q + 4'h1;
        end
      end
    end
  end

  assign bus.sdaFarOe = ackDrv_q | txDrv_q;
  assign bus.sclFarOe = 1'b0; // never stretches
endmodule : twi_far_end
`default_nettype wire

// [rtl/twi_device.sv]
// Purpose: multimaster two-wire interface with event sequencing
// Assumes: Avalon-MM slave, 8-bit data in low byte of 32
// Notes: seven-bit master and slave paths, flags clear in sequence
`timescale 1ns/1ps
`default_nettype none
`include "twi_defs.svh"
module twi_device
  import twi_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = 7'h10,
  parameter logic [15:0] DIV = `SCL_DIV
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // avalon slave
  input wire logic [1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // power and interrupt
  input wire logic haltMode,
  input wire logic globalMask,
  output logic irq,
  // bus
  twi_if.dev bus
);
  logic [7:0] ctrl_q, data_q, sh_q;
  logic evt_q, hdr_q, tra_q, busy_q, btf_q, address_match_flag_q, mst_q, sb_q;
  logic af_q, stop_detected_flag_q, arbitration_lost_flag_q, bus_error_flag_q, addrDone_q, s1Read_q;
  logic hideStop_q, stopArm_q, slvAct_q, slvRd_q, addrPh_q;
  logic sclS, sdaS, sclP_q, sdaP_q, sclOe_q, sdaOe_q;
  logic [3:0] bitCnt_q;
  logic [15:0] div_q;
  eng_state_t st_q;
  wire en = ctrl_q[`CTRL_EN];
  wire run = ~haltMode; // halt freezes control and engine; divider, line history and readdata still run
  pin_sync u_scl (.sys_clk(sys_clk), .rst(rst), .pinIn(bus.scl),
    .pinOut(sclS));
  pin_sync u_sda (.sys_clk(sys_clk), .rst(rst), .pinIn(bus.sda),
    .pinOut(sdaS));
  wire sclRise = sclS & ~sclP_q;
  wire sclFall = ~sclS & sclP_q;
  wire startC = sclS & sclP_q & sdaP_q & ~sdaS;
  wire stopC = sclS & sclP_q & ~sdaP_q & sdaS;
  wire inByte = bitCnt_q >= 4'h2; // pulses one and two excused
  wire rdS1 = read & address == `ADDR_STAT1;
  wire rdS2 = read & address == `ADDR_STAT2;
  wire rdDat = read & address == `ADDR_DATA;
  wire wrDat = write & address == `ADDR_DATA;
  wire wrCtl = write & address == `ADDR_CTRL;
  wire stall = hdr_q | sb_q | btf_q | address_match_flag_q | addrDone_q;
  wire tick = div_q == 16'h0000;
  wire mAct = mst_q & st_q != ST_IDLE;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  assign waitrequest = 1'b0; // zero wait states
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else begin
      case (address)
        `ADDR_CTRL: readdata <= {24'h00_0000, ctrl_q};
        `ADDR_STAT1: readdata <= {24'h00_0000, evt_q, hdr_q, tra_q,
          busy_q, btf_q, address_match_flag_q, mst_q, sb_q};
        // bit 0 is the general-call flag, not modelled, reads zero
        `ADDR_STAT2: readdata <= {27'h000_0000, af_q, stop_detected_flag_q,
          arbitration_lost_flag_q, bus_error_flag_q, 1'b0};
        default: readdata <= {24'h00_0000, data_q};
      endcase
    end
  end

  // one vector, gated by enable and the global mask
  assign irq = evt_q & ctrl_q[`CTRL_IE] & ~globalMask;

  // ----------------------------------------------------------------
  // control register; start auto-clears when sent
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (run) begin
      if (wrCtl) begin
        ctrl_q <= {2'b00, writedata[5:0]};
      end else if (!en) begin
        ctrl_q <= ctrl_q & 8'h22; // disable keeps stop only
      end else if (st_q == ST_START && tick && sclS) begin
        ctrl_q[`CTRL_START] <= 1'b0;
      end else if (st_q == ST_STOP && tick && sclS) begin
        ctrl_q[`CTRL_STOP] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // line history and divider
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
      div_q <= 16'h0000;
    end else begin
      sclP_q <= sclS;
      sdaP_q <= sdaS;
      div_q <= tick ? DIV : div_q - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // bit engine and event flags; a set beats a clear
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      {evt_q, hdr_q, tra_q, busy_q, btf_q, address_match_flag_q, mst_q, sb_q} <= 8'h00;
      {af_q, stop_detected_flag_q, arbitration_lost_flag_q, bus_error_flag_q, addrDone_q, s1Read_q} <= 6'h00;
      {hideStop_q, stopArm_q, slvAct_q, slvRd_q, addrPh_q} <= 5'h00;
      {sclOe_q, sdaOe_q} <= 2'b00;
      bitCnt_q <= 4'h0;
      sh_q <= 8'h00;
      data_q <= 8'h00;
    end else if (!run) begin
      // frozen: no acknowledge, nothing moves
    end else if (!en) begin
      st_q <= ST_IDLE;
      {evt_q, hdr_q, tra_q, btf_q, address_match_flag_q, mst_q, sb_q} <= 7'h00;
      {af_q, stop_detected_flag_q, arbitration_lost_flag_q, bus_error_flag_q, addrDone_q, s1Read_q} <= 6'h00;
      {slvAct_q, sclOe_q, sdaOe_q} <= 3'b000;
    end else begin
      // software clear sequences
      if (rdS1) begin
        s1Read_q <= 1'b1;
        address_match_flag_q <= 1'b0;
        if (btf_q & af_q) af_q <= 1'b0;
      end
      if (s1Read_q & (rdDat | wrDat)) begin
        s1Read_q <= 1'b0;
        btf_q <= 1'b0;
        sb_q <= 1'b0;
        hdr_q <= 1'b0;
        tra_q <= 1'b0;
      end
      if (s1Read_q & wrCtl) begin
        addrDone_q <= 1'b0;
        s1Read_q <= 1'b0;
      end
      if (wrDat) data_q <= writedata[7:0];
      if (wrDat & ~mst_q & writedata[7:0] == 8'hFF) btf_q <= 1'b0;
      if (rdS2) begin
        {af_q, arbitration_lost_flag_q, bus_error_flag_q, stop_detected_flag_q} <= 4'h0;
      end
      // slave release by stop set then clear
      if (~mst_q & btf_q & ctrl_q[`CTRL_STOP]) stopArm_q <= 1'b1;
      if (stopArm_q & ~ctrl_q[`CTRL_STOP]) begin
        stopArm_q <= 1'b0;
        btf_q <= 1'b0;
        hideStop_q <= 1'b1;
        {slvAct_q, sclOe_q, sdaOe_q} <= 3'b000;
      end
      // clear wins unless an event sets again below
      if (rdS1 | rdS2 | rdDat | wrDat | wrCtl) begin
        evt_q <= 1'b0;
      end
      // bus conditions
      if (startC | stopC) begin
        busy_q <= startC;
        if ((slvAct_q | mAct) & inByte & ~addrPh_q) begin
          bus_error_flag_q <= 1'b1;
          evt_q <= 1'b1;
        end else if (mAct & ~inByte & bitCnt_q != 4'h0) begin
          busy_q <= 1'b0; // transfer goes on
        end
        if (stopC & ~mst_q & slvAct_q & ~hideStop_q) begin
          stop_detected_flag_q <= 1'b1;
          evt_q <= 1'b1;
        end
        if (stopC) begin
          hideStop_q <= 1'b0;
          slvAct_q <= 1'b0;
          mst_q <= mst_q & ~(st_q == ST_STOP);
        end
        if (~mst_q) begin
          slvAct_q <= startC;
          addrPh_q <= startC;
          // the fall that ends a start is not a bit: count from -1
          bitCnt_q <= startC ? 4'hF : 4'h0;
        end
        sclOe_q <= 1'b0; // errors never stretch
      end
      // arbitration loss: we sent 1, line shows 0
      if (mAct & sclRise & ~sdaOe_q & ~sdaS & bitCnt_q < 4'h8
          & ~(tra_q == 1'b0 & ~addrPh_q)) begin
        arbitration_lost_flag_q <= 1'b1;
        evt_q <= 1'b1;
        mst_q <= 1'b0;
        st_q <= ST_IDLE;
        {sclOe_q, sdaOe_q} <= 2'b00;
      end
      // master engine
      case (st_q)
        ST_IDLE: begin
          if (ctrl_q[`CTRL_START] & ~busy_q & tick) begin
            mst_q <= 1'b1;
            sdaOe_q <= 1'b1;
            st_q <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            sclOe_q <= 1'b1;
            sb_q <= 1'b1;
            evt_q <= 1'b1;
            busy_q <= 1'b1;
            addrPh_q <= 1'b1;
            bitCnt_q <= 4'h0;
            st_q <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          sclOe_q <= 1'b1;
          // stop after the last byte may follow a pending byte-done
          if (tick & ctrl_q[`CTRL_STOP] & (btf_q | !stall)) begin
            sdaOe_q <= 1'b1;
            st_q <= ST_STOP;
          end else if (!stall & tick) begin
            sh_q <= data_q;
            sdaOe_q <= ~data_q[7];
            hdr_q <= 1'b0;
            st_q <= ST_BITS;
          end
        end
        ST_BITS: begin
          if (tick) begin
            sclOe_q <= ~sclOe_q;
            if (sclOe_q == 1'b0) begin
              if (bitCnt_q == 4'h8) begin
                bitCnt_q <= 4'h0;
                sdaOe_q <= 1'b0;
                if (sdaS) begin
                  af_q <= 1'b1;
                  evt_q <= 1'b1;
                  st_q <= ST_HOLD;
                end else if (addrPh_q) begin
                  addrPh_q <= 1'b0;
                  addrDone_q <= 1'b1;
                  evt_q <= 1'b1;
                  tra_q <= ~data_q[0]; // direction bit of the address
                  st_q <= ST_HOLD;
                end else begin
                  btf_q <= 1'b1;
                  tra_q <= 1'b1; // a byte went out
                  evt_q <= 1'b1;
                  st_q <= ST_HOLD;
                end
              end else begin
                bitCnt_q <= bitCnt_q + 4'h1;
                sdaOe_q <= (bitCnt_q == 4'h7) ? 1'b0 : ~sh_q[6];
                sh_q <= {sh_q[6:0], 1'b1};
              end
            end
          end
        end
        ST_STOP: begin
          sclOe_q <= 1'b0;
          if (tick & sclS) begin
            sdaOe_q <= 1'b0;
            mst_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
      // slave receive path; address match then byte events
      if (slvAct_q & ~mst_q & sclRise & bitCnt_q < 4'h8) begin
        sh_q <= {sh_q[6:0], sdaS};
      end
      if (slvAct_q & ~mst_q & sclFall) begin
        if (bitCnt_q == 4'h7) begin
          bitCnt_q <= 4'h8;
          if (addrPh_q & sh_q[7:1] == OWN_ADDR & ctrl_q[`CTRL_ACK]) begin
            sdaOe_q <= 1'b1;
            slvRd_q <= sh_q[0];
          end else if (~addrPh_q & ~slvRd_q) begin
            sdaOe_q <= ctrl_q[`CTRL_ACK];
            data_q <= sh_q;
          end
        end else if (bitCnt_q == 4'h8) begin
          bitCnt_q <= 4'h0;
          sdaOe_q <= 1'b0;
          if (addrPh_q) begin
            addrPh_q <= 1'b0;
            slvAct_q <= sdaOe_q;
            address_match_flag_q <= sdaOe_q;
            evt_q <= sdaOe_q;
          end else if (slvRd_q & sdaS) begin
            af_q <= 1'b1;
            btf_q <= 1'b1;
            evt_q <= 1'b1;
          end else begin
            btf_q <= 1'b1;
            tra_q <= slvRd_q;
            evt_q <= 1'b1;
          end
          sclOe_q <= 1'b1;
        end else begin
          bitCnt_q <= bitCnt_q + 4'h1;
        end
      end
      if (slvAct_q & ~mst_q & ~stall & sclOe_q) sclOe_q <= 1'b0;
    end
  end

  assign bus.sclDevOe = sclOe_q;
  assign bus.sdaDevOe = sdaOe_q;
endmodule : twi_device
`default_nettype wire

// [tb/twi_checker.sv]
// Purpose: wire and interrupt checks beside the two-wire pair
// Assumes: one clock domain, reset active high
// Notes: sees only the shared interface, the power inputs and the interrupt vector
`timescale 1ns/1ps
`default_nettype none
module twi_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wire levels and pull enables
  input wire logic scl,
  input wire logic sda,
  input wire logic sclDevOe,
  input wire logic sdaDevOe,
  input wire logic sclFarOe,
  input wire logic sdaFarOe,
  // power and interrupt
  input wire logic haltMode,
  input wire logic globalMask,
  input wire logic irq
);
  // ------------------------
  // assertions
  // ------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a held mask keeps the shared vector quiet
  masked_irq_a: assert property (
    globalMask && $past(globalMask) |-> !irq)
    else $error("irq seen while masked");
  // raising the mask drops the line within a cycle
  mask_drop_a: assert property (
    $rose(globalMask) |-> ##[0:1] !irq)
    else $error("irq not dropped by mask");
  // reset releases both lines and the vector
  dev_release_a: assert property (
    disable iff (1'b0) rst |-> !sclDevOe && !sdaDevOe && !irq)
    else $error("device holds a line in reset");
  far_release_a: assert property (
    disable iff (1'b0) rst |-> !sclFarOe && !sdaFarOe)
    else $error("far end holds a line in reset");
  // low wins on both open-drain lines
  wired_and_a: assert property (
    scl == !(sclDevOe || sclFarOe) && sda == !(sdaDevOe || sdaFarOe))
    else $error("wire level not resolved");
  // every clock edge the device makes is held for at least two further cycles
  clock_pace_a: assert property (
    $changed(sclDevOe) |=> $stable(sclDevOe)[*2])
    else $error("device clock changed too fast");
  // halted core never starts driving data
  halt_quiet_a: assert property (
    haltMode && $past(haltMode) && !$past(sdaDevOe) |-> !sdaDevOe)
    else $error("data driven while halted");
  // frozen registers cannot move the vector
  halt_freeze_a: assert property (
    haltMode && $past(haltMode) && $stable(globalMask) |-> $stable(irq))
    else $error("irq moved while halted");
endmodule : twi_checker
`default_nettype wire

// [tb/i2c_event_error_sequencing_test.sv]
// Purpose: device end against far end, register driven
// Assumes: readdata valid one edge after the read is taken
// Notes: event flag clears on any register access except a control read or a status register write
`timescale 1ns/1ps
`default_nettype none
`include "twi_defs.svh"
module i2c_event_error_sequencing_test import twi_pkg::*;;
  // ------------------------
  // signals
  // ------------------------
  localparam logic [6:0] FAR_ADDR = 7'h2A; // target address
  logic sys_clk, rst, read, write, waitrequest;
  logic haltMode, globalMask, irq, rxStrobe, misplaced;
  logic [1:0] address;
  logic [31:0] writedata, readdata;
  logic [7:0] txByte, rxByte, rv, b;
  int errorCnt, cmpCount, cyc;
  twi_if bus();
  twi_device #(.OWN_ADDR(7'h10)) i_twi_device (.sys_clk(sys_clk),
    .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .haltMode(haltMode),
    .globalMask(globalMask), .irq(irq), .bus(bus));
  twi_far_end #(.OWN_ADDR(FAR_ADDR)) i_twi_far_end (.sys_clk(sys_clk),
    .rst(rst), .bus(bus), .txByte(txByte), .rxByte(rxByte),
    .rxStrobe(rxStrobe), .misplaced(misplaced));
  twi_checker i_twi_checker (.sys_clk(sys_clk), .rst(rst),
    .scl(bus.scl), .sda(bus.sda), .sclDevOe(bus.sclDevOe),
    .sdaDevOe(bus.sdaDevOe), .sclFarOe(bus.sclFarOe),
    .sdaFarOe(bus.sdaFarOe), .haltMode(haltMode),
    .globalMask(globalMask), .irq(irq));
  // ------------------------
  // tasks
  // ------------------------
  task automatic finalReport();
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finalReport
  // compare one byte, count it
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // one avalon access; read data land in rv
  task automatic busOp(input logic wr, input logic [1:0] a,
                       input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {24'h00_0000, d};
    @(posedge sys_clk);
    while (waitrequest !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 100) errorCnt++;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge sys_clk);
    rv = readdata[7:0];
  endtask : busOp
  // bounded wait for the shared vector
  task automatic waitIrq(input string what);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(what, 8'h01, {7'h00, irq});
  endtask : waitIrq
  // bounded wait for a byte at the far end
  task automatic waitByte();
    int n;
    n = 0;
    while (rxStrobe !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) errorCnt++;
  endtask : waitByte
  // ------------------------
  // clock and timeout
  // ------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errorCnt++;
      finalReport();
    end
  end
  // ------------------------
  // main sequence
  // ------------------------
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 2'h0;
    writedata = 32'h0000_0000;
    haltMode = 1'b0;
    globalMask = 1'b0;
    txByte = 8'h00;
    void'($urandom(32'h9079_e840));
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    // registers start cleared
    for (int i = 0; i < 3; i++) begin
      busOp(1'b0, i[1:0], 8'h00);
      chk("reset value", 8'h00, rv);
    end
    // writes are ignored while halted
    busOp(1'b1, `ADDR_CTRL, 8'h20);
    haltMode <= 1'b1;
    busOp(1'b1, `ADDR_CTRL, 8'h00);
    haltMode <= 1'b0;
    busOp(1'b0, `ADDR_CTRL, 8'h00);
    chk("ctrl frozen", 8'h20, rv);
    // start, then mask and unmask the pending event
    txByte <= 8'($urandom);
    busOp(1'b1, `ADDR_CTRL, 8'h29);
    waitIrq("start irq");
    globalMask <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("irq masked", 8'h00, {7'h00, irq});
    globalMask <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("irq unmasked", 8'h01, {7'h00, irq});
    busOp(1'b0, `ADDR_STAT1, 8'h00);
    chk("start flags", 8'h83, rv & 8'h83);
    busOp(1'b1, `ADDR_DATA, {FAR_ADDR, 1'b0});
    waitIrq("address irq");
    busOp(1'b0, `ADDR_STAT1, 8'h00);
    chk("address flags", 8'h82, rv & 8'h8B);
    busOp(1'b1, `ADDR_CTRL, 8'h21);
    waitIrq("first byte irq");
    busOp(1'b0, `ADDR_STAT1, 8'h00);
    chk("tx flags", 8'hA8, rv & 8'hA8);
    // random bytes out; software waits for irq and checks busy between bytes, stop last
    for (int k = 0; k < 3; k++) begin
      b = 8'($urandom);
      busOp(1'b1, `ADDR_DATA, b);
      waitByte();
      chk("far byte", b, rxByte);
      if (k == 2) busOp(1'b1, `ADDR_CTRL, 8'h23);
      if (k < 2) begin
        waitIrq("byte irq");
        busOp(1'b0, `ADDR_STAT1, 8'h00);
        chk("byte flags", 8'hB8, rv & 8'hB8);
      end
    end
    repeat (300) @(posedge sys_clk);
    busOp(1'b0, `ADDR_STAT1, 8'h00);
    chk("master left", 8'h00, rv & 8'h12);
    // nobody answers this address
    busOp(1'b1, `ADDR_CTRL, 8'h29);
    waitIrq("restart irq");
    busOp(1'b0, `ADDR_STAT1, 8'h00);
    busOp(1'b1, `ADDR_DATA, {~FAR_ADDR, 1'b0});
    waitIrq("nack irq");
    busOp(1'b0, `ADDR_STAT2, 8'h00);
    chk("ack fail", 8'h10, rv & 8'h10);
    repeat (40) @(posedge sys_clk);
    busOp(1'b0, `ADDR_STAT2, 8'h00);
    chk("ack fail cleared", 8'h00, rv & 8'h10);
    busOp(1'b1, `ADDR_CTRL, 8'h23);
    repeat (300) @(posedge sys_clk);
    busOp(1'b0, `ADDR_STAT1, 8'h00);
    chk("slave again", 8'h00, rv & 8'h12);
    chk("no misplaced", 8'h00, {7'h00, misplaced});
    finalReport();
  end
endmodule : i2c_event_error_sequencing_test
`default_nettype wire
